// file: common/smrc_params.svh
// constants and rule summary for the supply monitor reset combiner
//
// Summary of operation
// - Power-on monitors on core and io rails always active, reset held through power-up.
// - After power-up, brown-out watches io rail unless the configuration bit disables it, core rail only with regulator on.
// - Any monitored rail below its trip point pulls the reset pin low.
// - With regulator on, core over-voltage also pulls the reset pin low.
// - After a fault clears, the pin stays low for a release delay.
// - One configuration bit disables brown-out on both rails.
// - Strap low uses internal regulator, high external; monitors follow the strap.
// - Reset logic takes watchdog reset and combined power monitor reset.
// - Watchdog not serviced within its window requests a processor reset.
`ifndef SMRC_PARAMS_SVH
`define SMRC_PARAMS_SVH

//----------------------------------------
// timing
//----------------------------------------
`define SMRC_CLK_PERIOD_NS   10
`define SMRC_RELEASE_US      800
`define SMRC_RELEASE_CYCLES  ((`SMRC_RELEASE_US * 1000) / `SMRC_CLK_PERIOD_NS)
`define SMRC_WDOG_TIMEOUT    65536
`define SMRC_WDOG_RST_CYCLES 512
`define SMRC_CNT_W           20

`endif

// file: common/smrc_pkg.sv
// types for the supply monitor reset combiner
package smrc_pkg;
	typedef enum logic [1:0] {
		SMRC_POWERUP = 2'b00,
		SMRC_RUN     = 2'b01,
		SMRC_FAULT   = 2'b11,
		SMRC_RELEASE = 2'b10
	} smrc_state_e;
	typedef logic [19:0] smrc_cnt_t;
endpackage

// file: rtl/smrc_sync3.sv
// three-stage synchroniser with agreement qualifier
module smrc_sync3 #(
	parameter logic RST_VAL = 1'b0
) (
	// clock and reset
	input  wire logic i_core_clk,
	input  wire logic i_rst,
	// data
	input  wire logic i_async,
	output logic      o_sync
);
	logic s1_ff;
	logic s2_ff;
	logic s3_ff;
	logic out_ff;
	wire  agree = (s2_ff == s3_ff);

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			s1_ff  <= RST_VAL;
			s2_ff  <= RST_VAL;
			s3_ff  <= RST_VAL;
			out_ff <= RST_VAL;
		end else begin
			s1_ff <= i_async;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			if (agree)
				out_ff <= s3_ff;
		end
	end
	assign o_sync = out_ff;
endmodule

// file: rtl/smrc_top.sv
// supply monitor reset combiner top
`include "smrc_params.svh"
module smrc_top
	import smrc_pkg::*;
#(
	parameter int RELEASE_CYCLES = `SMRC_RELEASE_CYCLES,
	parameter int WDOG_TIMEOUT   = `SMRC_WDOG_TIMEOUT
) (
	// clock and reset
	input  wire logic i_core_clk,
	input  wire logic i_rst,
	// analog comparators, high when rail is below trip point or above ov trip
	input  wire logic i_core_por_low,
	input  wire logic i_io_por_low,
	input  wire logic i_core_bor_low,
	input  wire logic i_io_bor_low,
	input  wire logic i_core_ov_high,
	// strap and configuration
	input  wire logic i_regulator_disable_strap,
	input  wire logic i_brownout_config,
	// watchdog
	input  wire logic i_wdog_enable,
	input  wire logic i_wdog_service,
	// reset pin, open drain
	input  wire logic i_reset_pin_n,
	output logic      o_reset_pin_n_out,
	output logic      o_reset_pin_n_oe,
	// status and resets
	output logic      o_core_regulator_en,
	output logic      o_watchdog_reset,
	output logic      o_power_monitor_reset,
	output logic      o_device_reset
);
	//----------------------------------------
	// input synchronisation
	//----------------------------------------
	logic core_por_s, io_por_s, core_bor_s, io_bor_s, core_ov_s, pin_n_s, strap_s;
	smrc_sync3 #(.RST_VAL(1'b1)) u_s0 (.i_core_clk(i_core_clk), .i_rst(i_rst),
		.i_async(i_core_por_low), .o_sync(core_por_s));
	smrc_sync3 #(.RST_VAL(1'b1)) u_s1 (.i_core_clk(i_core_clk), .i_rst(i_rst),
		.i_async(i_io_por_low), .o_sync(io_por_s));
	smrc_sync3 #(.RST_VAL(1'b1)) u_s2 (.i_core_clk(i_core_clk), .i_rst(i_rst),
		.i_async(i_core_bor_low), .o_sync(core_bor_s));
	smrc_sync3 #(.RST_VAL(1'b1)) u_s3 (.i_core_clk(i_core_clk), .i_rst(i_rst),
		.i_async(i_io_bor_low), .o_sync(io_bor_s));
	smrc_sync3 #(.RST_VAL(1'b0)) u_s4 (.i_core_clk(i_core_clk), .i_rst(i_rst),
		.i_async(i_core_ov_high), .o_sync(core_ov_s));
	smrc_sync3 #(.RST_VAL(1'b0)) u_s5 (.i_core_clk(i_core_clk), .i_rst(i_rst),
		.i_async(i_reset_pin_n), .o_sync(pin_n_s));
	smrc_sync3 #(.RST_VAL(1'b0)) u_s6 (.i_core_clk(i_core_clk), .i_rst(i_rst),
		.i_async(i_regulator_disable_strap), .o_sync(strap_s));

	//----------------------------------------
	// strap capture
	//----------------------------------------
	// strap is sampled once after reset; a board strap must not toggle at run time
	logic strap_ff, strap_valid_ff;
	logic [2:0] strap_wait_ff;
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			strap_ff       <= 1'b0;
			strap_valid_ff <= 1'b0;
			strap_wait_ff  <= 3'h0;
		end else if (!strap_valid_ff) begin
			strap_wait_ff <= strap_wait_ff + 3'h1;
			if (strap_wait_ff == 3'h7) begin
				strap_ff       <= strap_s;
				strap_valid_ff <= 1'b1;
			end
		end
	end
	wire reg_en = strap_valid_ff && !strap_ff;

	//----------------------------------------
	// fault combine
	//----------------------------------------
	logic powered_ff; // set once initial power-up completes
	wire por_fault = core_por_s || io_por_s;
	wire bor_on    = powered_ff && !i_brownout_config;
	wire bor_fault = bor_on && (io_bor_s || (reg_en && core_bor_s));
	wire ov_fault  = reg_en && core_ov_s;
	wire fault     = por_fault || bor_fault || ov_fault || !strap_valid_ff;

	//----------------------------------------
	// release sequencer
	//----------------------------------------
	smrc_state_e state_ff, nxt_state;
	smrc_cnt_t   rel_cnt_ff;
	wire rel_done = (rel_cnt_ff == smrc_cnt_t'(RELEASE_CYCLES - 1));
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			SMRC_POWERUP: if (!fault) nxt_state = SMRC_RELEASE;
			SMRC_RUN:     if (fault) nxt_state = SMRC_FAULT;
			SMRC_FAULT:   if (!fault) nxt_state = SMRC_RELEASE;
			SMRC_RELEASE: begin
				if (fault)
					nxt_state = SMRC_FAULT;
				else if (rel_done)
					nxt_state = SMRC_RUN;
			end
		endcase
	end
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			state_ff   <= SMRC_POWERUP;
			rel_cnt_ff <= '0;
			powered_ff <= 1'b0;
		end else begin
			state_ff   <= nxt_state;
			rel_cnt_ff <= (state_ff == SMRC_RELEASE && !fault) ? rel_cnt_ff + 1'b1 : '0;
			if (state_ff == SMRC_RELEASE && rel_done)
				powered_ff <= 1'b1;
		end
	end
	wire pm_reset = (nxt_state != SMRC_RUN);

	//----------------------------------------
	// processor watchdog
	//----------------------------------------
	smrc_cnt_t wd_cnt_ff;
	logic [9:0] wd_rst_ff;
	wire wd_expire = i_wdog_enable && (wd_cnt_ff == smrc_cnt_t'(WDOG_TIMEOUT - 1));
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			wd_cnt_ff <= '0;
			wd_rst_ff <= 10'h000;
		end else begin
			if (!i_wdog_enable || i_wdog_service || wd_expire || o_device_reset)
				wd_cnt_ff <= '0;
			else
				wd_cnt_ff <= wd_cnt_ff + 1'b1;
			if (wd_expire)
				wd_rst_ff <= 10'(`SMRC_WDOG_RST_CYCLES);
			else if (wd_rst_ff != 10'h000)
				wd_rst_ff <= wd_rst_ff - 10'h001;
		end
	end
	wire wd_reset = (wd_rst_ff != 10'h000) || wd_expire;

	//----------------------------------------
	// outputs
	//----------------------------------------
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_reset_pin_n_out     <= 1'b0;
			o_reset_pin_n_oe      <= 1'b1;
			o_core_regulator_en   <= 1'b0;
			o_watchdog_reset      <= 1'b0;
			o_power_monitor_reset <= 1'b1;
			o_device_reset        <= 1'b1;
		end else begin
			o_reset_pin_n_out     <= 1'b0;
			o_reset_pin_n_oe      <= pm_reset || wd_reset;
			o_core_regulator_en   <= reg_en;
			o_watchdog_reset      <= wd_reset;
			o_power_monitor_reset <= pm_reset;
			o_device_reset        <= wd_reset || pm_reset || !pin_n_s;
		end
	end

	//----------------------------------------
	// check helpers
	//----------------------------------------
	// how long the combined fault has been clear, saturating
	smrc_cnt_t  clr_run_ff;
	// how long the watchdog request has stood, saturating
	logic [9:0] wd_hi_cnt_ff;
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			clr_run_ff   <= '0;
			wd_hi_cnt_ff <= 10'h000;
		end else begin
			if (fault)
				clr_run_ff <= '0;
			else if (clr_run_ff != '1)
				clr_run_ff <= clr_run_ff + 1'b1;
			if (!o_watchdog_reset)
				wd_hi_cnt_ff <= 10'h000;
			else if (wd_hi_cnt_ff != 10'h3FF)
				wd_hi_cnt_ff <= wd_hi_cnt_ff + 10'h001;
		end
	end

	//----------------------------------------
	// checks
	//----------------------------------------
	chk_pin_on_por: assert property (@(posedge i_core_clk) disable iff (i_rst)
		por_fault |=> o_reset_pin_n_oe) else $error("pin not driven during por");
	chk_bor_io: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(bor_on && io_bor_s) |=> o_power_monitor_reset) else $error("io brownout missed");
	chk_bor_core_gate: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(core_bor_s && !reg_en) |-> !bor_fault || io_bor_s) else $error("core bor not gated");
	chk_ov_gate: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(ov_fault) |=> o_reset_pin_n_oe) else $error("overvoltage did not reset");
	sequence s_fault_clear;
		$fell(fault) && state_ff != SMRC_RUN;
	endsequence
	chk_release_hold: assert property (@(posedge i_core_clk) disable iff (i_rst)
		s_fault_clear |-> o_power_monitor_reset [*2]) else $error("release too early");
	chk_bor_disable: assert property (@(posedge i_core_clk) disable iff (i_rst)
		i_brownout_config |-> !bor_fault) else $error("brownout not disabled");
	chk_reg_strap: assert property (@(posedge i_core_clk) disable iff (i_rst)
		strap_valid_ff |=> o_core_regulator_en == !strap_ff) else $error("regulator mismatch");
	chk_wdog_fire: assert property (@(posedge i_core_clk) disable iff (i_rst)
		wd_expire |=> o_watchdog_reset [*8]) else $error("watchdog reset short");
	chk_dev_reset: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(wd_reset || pm_reset || !pin_n_s) |=> o_device_reset) else $error("device reset missed");
	chk_dev_release: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!(wd_reset || pm_reset || !pin_n_s) |=> !o_device_reset) else $error("reset stuck");
	sequence s_monitor_drop;
		$fell(o_power_monitor_reset);
	endsequence
	sequence s_wdog_drop;
		$fell(o_watchdog_reset);
	endsequence
	chk_powerup_hold: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!powered_ff |-> o_reset_pin_n_oe && o_device_reset) else $error("power-up not held");
	chk_release_len: assert property (@(posedge i_core_clk) disable iff (i_rst)
		s_monitor_drop |-> clr_run_ff > RELEASE_CYCLES) else $error("release delay short");
	chk_strap_frozen: assert property (@(posedge i_core_clk) disable iff (i_rst)
		strap_valid_ff |=> $stable(strap_ff)) else $error("strap changed after capture");
	chk_wdog_width: assert property (@(posedge i_core_clk) disable iff (i_rst)
		s_wdog_drop |-> wd_hi_cnt_ff == (`SMRC_WDOG_RST_CYCLES + 1))
		else $error("watchdog width wrong");
endmodule

// file: verification/smrc_board_model.sv
// board side model: reset pin pull-up and regulator strap
module smrc_board_model (
	// from device
	input  wire logic i_pin_oe,
	input  wire logic i_pin_out,
	// board controls
	input  wire logic i_ext_low,
	input  wire logic i_strap_high,
	// to device
	output logic      o_pin_n,
	output logic      o_strap
);
	timeunit 1ns;
	timeprecision 1ps;
	// pull-up wins unless someone sinks the line
	assign o_pin_n = ((i_pin_oe && !i_pin_out) || i_ext_low) ? 1'b0 : 1'b1;
	assign o_strap = i_strap_high;
endmodule

// file: verification/testbench.sv
// self-checking bench for the supply monitor reset combiner
`include "smrc_params.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	// short release and watchdog counts keep the run brief
	localparam int REL = 20;
	localparam int WDT = 50;
	logic clk, rst, cpl, ipl, cbl, ibl, ovh, strap_hi, cfg, wde, wds, ext;
	logic pin_n, strap, pout, poe, reg_en, wd, pmr, dev;
	int   failures, num_checks, cycles, n, k;
	//----------------------------------------
	// design and board
	//----------------------------------------
	smrc_top #(.RELEASE_CYCLES(REL), .WDOG_TIMEOUT(WDT)) smrc_top_i (
		.i_core_clk(clk), .i_rst(rst), .i_core_por_low(cpl), .i_io_por_low(ipl),
		.i_core_bor_low(cbl), .i_io_bor_low(ibl), .i_core_ov_high(ovh),
		.i_regulator_disable_strap(strap), .i_brownout_config(cfg),
		.i_wdog_enable(wde), .i_wdog_service(wds), .i_reset_pin_n(pin_n),
		.o_reset_pin_n_out(pout), .o_reset_pin_n_oe(poe), .o_core_regulator_en(reg_en),
		.o_watchdog_reset(wd), .o_power_monitor_reset(pmr), .o_device_reset(dev));
	smrc_board_model smrc_board_model_i (.i_pin_oe(poe), .i_pin_out(pout),
		.i_ext_low(ext), .i_strap_high(strap_hi), .o_pin_n(pin_n), .o_strap(strap));
	initial clk = 1'b0;
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			failures++;
			end_sim();
		end
	end
	//----------------------------------------
	// helpers
	//----------------------------------------
	task cyc(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask
	task chk(input logic g, input logic e, input string nm);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s exp %b got %b", nm, e, g);
		end
	endtask
	task end_sim();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// reference: which rail faults count right now
	function automatic logic model();
		return (ibl && !cfg) || (cbl && !cfg && !strap_hi) || (ovh && !strap_hi) || cpl || ipl;
	endfunction
	task set(input int s, input logic v);
		case (s)
			0: ibl = v;
			1: cbl = v;
			2: ovh = v;
			default: cpl = v;
		endcase
	endtask
	// hold a fault a random while, then watch the release delay
	task hit(input int s);
		int   d;
		logic e;
		d = $urandom % 8;
		set(s, 1'b1);
		cyc(10 + d);
		e = model();
		chk(pmr, e, "pmr");
		chk(poe, e, "oe");
		chk(dev, e, "dev");
		chk(pout, 1'b0, "pout");
		set(s, 1'b0);
		// four synchroniser edges, then the release count
		cyc(REL + 4);
		chk(pmr, e, "pmr");
		cyc(1);
		chk(pmr, 1'b0, "pmr");
		chk(poe, 1'b0, "oe");
		cyc(20);
		chk(dev, 1'b0, "dev");
	endtask
	//----------------------------------------
	// main sequence
	//----------------------------------------
	initial begin
		{cbl, ibl, ovh, strap_hi, cfg, wde, wds, ext} = 8'h00;
		{rst, cpl, ipl} = 3'h7;
		void'($urandom(9061));
		cyc(2);
		rst = 1'b0;
		cyc(30);
		chk(pmr, 1'b1, "pmr");
		chk(dev, 1'b1, "dev");
		cpl = 1'b0;
		ipl = 1'b0;
		cyc(15);
		chk(pmr, 1'b1, "pmr");
		cyc(30);
		chk(pmr, 1'b0, "pmr");
		chk(reg_en, 1'b1, "reg_en");
		for (k = 0; k < 4; k++) hit(k);
		cfg = 1'b1;
		hit(0);
		hit(1);
		cfg = 1'b0;
		ext = 1'b1;
		cyc(8);
		chk(dev, 1'b1, "dev");
		chk(poe, 1'b0, "oe");
		chk(pmr, 1'b0, "pmr");
		ext = 1'b0;
		cyc(8);
		chk(dev, 1'b0, "dev");
		wde = 1'b1;
		repeat (10) begin
			wds = 1'b1;
			cyc(1);
			wds = 1'b0;
			cyc(20);
			chk(wd, 1'b0, "wd");
		end
		for (n = 0; n < 80 && wd !== 1'b1; n++) cyc(1);
		chk(wd, 1'b1, "wd");
		// 20 cycles already waited since the last service
		chk(n == WDT - 20, 1'b1, "wd_time");
		cyc(3);
		chk(dev, 1'b1, "dev");
		chk(poe, 1'b1, "oe");
		wde = 1'b0;
		for (n = 0; n < 700 && wd !== 1'b0; n++) cyc(1);
		chk(wd, 1'b0, "wd");
		// request stands hold count plus one; 3 cycles already waited
		chk(n == `SMRC_WDOG_RST_CYCLES - 2, 1'b1, "wd_len");
		cyc(10);
		chk(dev, 1'b0, "dev");
		strap_hi = 1'b1;
		rst = 1'b1;
		cyc(2);
		rst = 1'b0;
		cyc(60);
		chk(reg_en, 1'b0, "reg_en");
		chk(pmr, 1'b0, "pmr");
		hit(1);
		hit(2);
		hit(0);
		hit(3);
		hit($urandom % 4);
		end_sim();
	end
endmodule
